// File: src/pmcs_top.sv
// Behaviour
// - Two-bit power state reads back and is writable; 0 on, 3 hot-off.
// - Codes one and two are reserved sleep states, unsupported.
// - Context-kept flag at bit 3 resets to one.
// - Wake-event enable at bit 8 permits wake messages; resets zero.
// - Wake-event enable survives hot reset; only fundamental reset clears.
// - Wake status bit 15 sets on own wake event; write one clears.
// - Forwarded wake messages never set wake status.
// - Upstream port never sets wake status.
// - Data select, data scale and data byte read zero.
// - Bus power support and clock enable bits read zero.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "pmcs_map.svh"

module pmcs_top #(
    parameter bit UPSTREAM_PORT = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic hot_reset,
    input pmcs_pkg::pmcs_apb_req_type apb_req,
    output pmcs_pkg::pmcs_apb_rsp_type apb_rsp,
    input wire logic own_wake_event,
    input wire logic fwd_wake_event,
    output logic wake_msg_req,
    output logic context_kept_flag,
    output logic [1:0] power_state_field,
    output logic irq
);
    import pmcs_pkg::*;

    // ========================================
    // Bus decode
    logic acc;
    logic wr;
    logic hit_cs;
    logic hit_is;
    logic hit_im;
    logic hit_ev;
    logic [31:0] wd;
    logic [1:0] ps_q;
    logic ctx_q;
    logic [`PMCS_IRQ_W-1:0] ist_q;
    logic [`PMCS_IRQ_W-1:0] imask_q;
    logic [`PMCS_IRQ_W-1:0] ist_set;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic err_q;
    logic gen_wake;
    logic ps_we;
    pmcs_sticky_type sticky_q;

    // Access phase; slave always ready in the access cycle
    assign acc = apb_req.psel && apb_req.penable;
    assign wr = acc && apb_req.pwrite;
    assign wd = apb_req.pwdata;
    assign hit_cs = apb_req.paddr == `PMCS_CTRL_STAT_OFF;
    assign hit_is = apb_req.paddr == `PMCS_INT_STAT_OFF;
    assign hit_im = apb_req.paddr == `PMCS_INT_MASK_OFF;
    assign hit_ev = apb_req.paddr == `PMCS_EVENT_OFF;

    // ========================================
    // Power state and context flag
    // Reserved codes rejected
    assign ps_we = wr && hit_cs &&
        (wd[`PMCS_POWER_STATE_FIELD_MSB:`PMCS_POWER_STATE_FIELD_LSB] == `PMCS_PS_ON ||
         wd[`PMCS_POWER_STATE_FIELD_MSB:`PMCS_POWER_STATE_FIELD_LSB] == `PMCS_PS_HOTOFF);

    // Power state write; reserved codes ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ps_q <= `PMCS_POWER_STATE_FIELD_RST;
        end else if (hot_reset) begin
            ps_q <= `PMCS_POWER_STATE_FIELD_RST;
        end else if (ps_we) begin
            ps_q <= wd[`PMCS_POWER_STATE_FIELD_MSB:`PMCS_POWER_STATE_FIELD_LSB];
        end
    end

    // Context flag, loadable by firmware, default one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctx_q <= `PMCS_CTX_RST;
        end else if (hot_reset) begin
            ctx_q <= `PMCS_CTX_RST;
        end else if (wr && hit_cs) begin
            ctx_q <= wd[`PMCS_CTX_BIT];
        end
    end

    // ========================================
    // Wake events
    // Forwarded events ignored; upstream never generates
    assign gen_wake = own_wake_event && !UPSTREAM_PORT;

    pmcs_sticky u_sticky (
        .pclk(pclk),
        .presetn(presetn),
        .wen_we(wr && hit_cs),
        .wen_wd(wd[`PMCS_WEN_BIT]),
        .wst_clr(wr && hit_cs && wd[`PMCS_WST_BIT]),
        .wst_set(gen_wake),
        .sticky_q(sticky_q)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_msg_req <= 1'b0;
        end else begin
            wake_msg_req <= gen_wake && sticky_q.wake_event_enable;
        end
    end

    assign power_state_field = ps_q;
    assign context_kept_flag = ctx_q;

    // ========================================
    // Interrupt status and mask
    assign ist_set[`PMCS_IRQ_WAKE] = gen_wake;
    assign ist_set[`PMCS_IRQ_PSCHG] = ps_we &&
        (wd[`PMCS_POWER_STATE_FIELD_MSB:`PMCS_POWER_STATE_FIELD_LSB] != ps_q);

    // Set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_q <= '0;
        end else begin
            ist_q <= ist_set | (ist_q &
                ~((wr && hit_is) ? wd[`PMCS_IRQ_W-1:0] : '0));
        end
    end

    // Mask register, one enables the source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imask_q <= '0;
        end else if (wr && hit_im) begin
            imask_q <= wd[`PMCS_IRQ_W-1:0];
        end
    end

    assign irq = |(ist_q & imask_q);

    // ========================================
    // Read data
    // Unused fields read zero; reserved zero
    always_comb begin
        rdata_d = '0;
        if (hit_cs) begin
            rdata_d[`PMCS_POWER_STATE_FIELD_MSB:`PMCS_POWER_STATE_FIELD_LSB] = ps_q;
            rdata_d[`PMCS_CTX_BIT] = ctx_q;
            rdata_d[`PMCS_WEN_BIT] = sticky_q.wake_event_enable;
            rdata_d[`PMCS_WST_BIT] = sticky_q.wake_event_status;
        end else if (hit_is) begin
            rdata_d[`PMCS_IRQ_W-1:0] = ist_q;
        end else if (hit_im) begin
            rdata_d[`PMCS_IRQ_W-1:0] = imask_q;
        end
    end

    // Read data captured in setup cycle, shown in access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= '0;
            err_q <= 1'b0;
        end else if (apb_req.psel && !apb_req.penable) begin
            rdata_q <= apb_req.pwrite ? 32'h0000_0000 : rdata_d;
            err_q <= !(hit_cs || hit_is || hit_im || hit_ev);
        end
    end

    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = acc && err_q;
    assign apb_rsp.prdata = rdata_q;

    // ========================================
    // Assertions
    // Reserved code write on the control word
    sequence reserved_write_s;
        wr && hit_cs && (wd[1:0] == 2'h1 || wd[1:0] == 2'h2);
    endsequence

    // Setup cycle of a control word read
    sequence cs_read_setup_s;
        apb_req.psel && !apb_req.penable && !apb_req.pwrite && hit_cs;
    endsequence

    // Control word read, matched at its access edge
    sequence cs_read_s;
        cs_read_setup_s ##1 acc;
    endsequence

    // Setup cycle that hits no register
    sequence unmapped_setup_s;
        apb_req.psel && !apb_req.penable &&
            !(hit_cs || hit_is || hit_im || hit_ev);
    endsequence

    // Own wake event while wake messages are enabled
    sequence enabled_wake_s;
        gen_wake && sticky_q.wake_event_enable;
    endsequence

    // Write of a one to the wake status bit
    sequence status_clear_s;
        wr && hit_cs && wd[`PMCS_WST_BIT];
    endsequence

    // ========================================
    // Power state checks
    // Reserved codes leave the field untouched
    ps_reserved_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (reserved_write_s and !hot_reset) |=> $stable(ps_q))
        else $error("reserved power state code was stored");

    // Only the on and hot-off codes are ever held
    ps_range_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ps_q != `PMCS_PS_SLEEP1 && ps_q != `PMCS_PS_SLEEP2)
        else $error("power state holds a reserved code");

    // Hot-off write is taken
    ps_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && hit_cs && wd[1:0] == `PMCS_PS_HOTOFF && !hot_reset
        |=> power_state_field == `PMCS_PS_HOTOFF)
        else $error("hot-off write not taken");

    // Return to fully on is taken
    ps_on_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && hit_cs && wd[1:0] == `PMCS_PS_ON && !hot_reset
        |=> power_state_field == `PMCS_PS_ON)
        else $error("fully on write not taken");

    // Hot reset brings back fully on with context kept
    hot_defaults_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        hot_reset |=> power_state_field == `PMCS_PS_ON && context_kept_flag)
        else $error("hot reset left state or context flag");

    // Context flag follows a control word write
    ctx_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && hit_cs && !hot_reset
        |=> context_kept_flag == $past(wd[`PMCS_CTX_BIT]))
        else $error("context flag write not taken");

    // ========================================
    // Wake event checks
    // Own event sets the status bit
    wake_set_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        gen_wake |=> sticky_q.wake_event_status)
        else $error("wake status not set by own event");

    // Write of one clears the status when no event competes
    wst_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (status_clear_s and !gen_wake) |=> !sticky_q.wake_event_status)
        else $error("wake status not cleared by write of one");

    // Status holds without an event or a clear
    wst_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !gen_wake && !(wr && hit_cs && wd[`PMCS_WST_BIT])
        |=> $stable(sticky_q.wake_event_status))
        else $error("wake status changed on its own");

    // Forwarded messages leave the status alone
    fwd_only_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        fwd_wake_event && !own_wake_event && !sticky_q.wake_event_status
        |=> !sticky_q.wake_event_status)
        else $error("forwarded event set wake status");

    // Upstream flavour never shows the status
    upstream_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        UPSTREAM_PORT |-> !sticky_q.wake_event_status)
        else $error("upstream port shows wake status");

    // Hot reset leaves the enable bit alone
    hot_keep_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        hot_reset && !(wr && hit_cs)
        |=> $stable(sticky_q.wake_event_enable))
        else $error("hot reset changed wake enable");

    // Enable bit follows a control word write
    wen_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && hit_cs
        |=> sticky_q.wake_event_enable == $past(wd[`PMCS_WEN_BIT]))
        else $error("wake enable write not taken");

    // No message while disabled
    msg_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wake_msg_req |-> $past(sticky_q.wake_event_enable))
        else $error("wake message while disabled");

    // Enabled own event is sent as a message
    msg_send_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        enabled_wake_s |=> wake_msg_req)
        else $error("enabled wake event not sent");

    // ========================================
    // Read data checks
    // Unimplemented fields read zero
    zero_fields_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc && hit_cs && !apb_req.pwrite
        |-> apb_rsp.prdata[31:16] == 16'h0000
            && apb_rsp.prdata[14:9] == 6'h00)
        else $error("unimplemented field reads nonzero");

    // Reserved bit positions read zero
    reserved_bits_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc && hit_cs && !apb_req.pwrite
        |-> apb_rsp.prdata[2] == 1'b0 && apb_rsp.prdata[7:4] == 4'h0)
        else $error("reserved bit reads nonzero");

    // Power state read back as held at the setup edge
    read_state_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        cs_read_s |-> apb_rsp.prdata[1:0] == $past(ps_q))
        else $error("power state read back wrong");

    // Enable bit read back
    read_enable_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        cs_read_s |-> apb_rsp.prdata[`PMCS_WEN_BIT]
            == $past(sticky_q.wake_event_enable))
        else $error("wake enable read back wrong");

    // Status bit read back
    read_status_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        cs_read_s |-> apb_rsp.prdata[`PMCS_WST_BIT]
            == $past(sticky_q.wake_event_status))
        else $error("wake status read back wrong");

    // Unmapped address answers with an error
    unmapped_err_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        unmapped_setup_s ##1 acc |-> apb_rsp.pslverr)
        else $error("unmapped access without error");

    // Enabled wake source raises the interrupt
    irq_wake_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        gen_wake && imask_q[`PMCS_IRQ_WAKE] && !(wr && hit_im) |=> irq)
        else $error("wake interrupt not raised");
endmodule

// File: src/pmcs_map.svh
`ifndef PMCS_MAP_SVH
`define PMCS_MAP_SVH

// Register byte offsets
`define PMCS_CTRL_STAT_OFF 12'h0c4
`define PMCS_INT_STAT_OFF 12'h100
`define PMCS_INT_MASK_OFF 12'h104
`define PMCS_EVENT_OFF 12'h108

// Field positions in the control and status word
`define PMCS_POWER_STATE_FIELD_LSB 0
`define PMCS_POWER_STATE_FIELD_MSB 1
`define PMCS_CTX_BIT 3
`define PMCS_WEN_BIT 8
`define PMCS_WST_BIT 15

// Reset values
`define PMCS_POWER_STATE_FIELD_RST 2'h0
`define PMCS_CTX_RST 1'h1
`define PMCS_WEN_RST 1'h0
`define PMCS_WST_RST 1'h0

// Power state codes
`define PMCS_PS_ON 2'h0
`define PMCS_PS_SLEEP1 2'h1
`define PMCS_PS_SLEEP2 2'h2
`define PMCS_PS_HOTOFF 2'h3

// Interrupt status bit positions
`define PMCS_IRQ_WAKE 0
`define PMCS_IRQ_PSCHG 1
`define PMCS_IRQ_W 2

`endif

// File: src/pmcs_pkg.sv
package pmcs_pkg;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pmcs_apb_req_type;

    // APB answer to the master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pmcs_apb_rsp_type;

    // Sticky wake bits held across hot reset
    typedef struct packed {
        logic wake_event_enable;
        logic wake_event_status;
    } pmcs_sticky_type;

endpackage

// File: src/pmcs_sticky.sv
`timescale 1ns/10ps
`include "pmcs_map.svh"

module pmcs_sticky (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wen_we,
    input wire logic wen_wd,
    input wire logic wst_clr,
    input wire logic wst_set,
    output pmcs_pkg::pmcs_sticky_type sticky_q
);
    import pmcs_pkg::*;

    logic wen_q;
    logic wst_q;

    // Only fundamental reset reaches these bits; hot reset is ignored
    // Sticky enable bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wen_q <= `PMCS_WEN_RST;
        end else if (wen_we) begin
            wen_q <= wen_wd;
        end
    end

    // Set wins over a write-one clear in the same cycle
    // Sticky status set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wst_q <= `PMCS_WST_RST;
        end else if (wst_set) begin
            wst_q <= 1'b1;
        end else if (wst_clr) begin
            wst_q <= 1'b0;
        end
    end

    // One driver for the packed pair, so no process shares the struct
    assign sticky_q = '{wake_event_enable: wen_q,
        wake_event_status: wst_q};

endmodule

// File: verif/power_mgmt_control_status_bench.sv
`timescale 1ns/10ps

module power_mgmt_control_status_bench;
    import pmcs_pkg::*;

    logic pclk;
    logic presetn;
    logic hot_reset;
    logic own_wake_event;
    logic fwd_wake_event;
    logic wake_msg_req;
    logic context_kept_flag;
    logic [1:0] power_state_field;
    logic irq;
    logic up_msg;
    logic [31:0] up_rd;
    logic [31:0] rd;
    logic err;
    int num_errors;
    int checked;
    int cycles;
    pmcs_apb_req_type apb_req;
    pmcs_apb_rsp_type apb_rsp;
    pmcs_apb_rsp_type up_rsp;

    // =====================================================
    // Clock, design instances
    always #2 pclk = ~pclk;

    pmcs_top i_dut (
        .pclk(pclk), .presetn(presetn), .hot_reset(hot_reset),
        .apb_req(apb_req), .apb_rsp(apb_rsp),
        .own_wake_event(own_wake_event), .fwd_wake_event(fwd_wake_event),
        .wake_msg_req(wake_msg_req), .context_kept_flag(context_kept_flag),
        .power_state_field(power_state_field), .irq(irq)
    );

    // Upstream flavour sharing every input
    pmcs_top #(.UPSTREAM_PORT(1'b1)) i_up (
        .pclk(pclk), .presetn(presetn), .hot_reset(hot_reset),
        .apb_req(apb_req), .apb_rsp(up_rsp),
        .own_wake_event(own_wake_event), .fwd_wake_event(fwd_wake_event),
        .wake_msg_req(up_msg), .context_kept_flag(), .power_state_field(),
        .irq()
    );

    // =====================================================
    // Verdict, comparison and timeout
    task give_verdict;
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
            num_errors++;
        end
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            give_verdict;
        end
    end

    // =====================================================
    // APB transfer: setup, access until pready, then release
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
            pwdata: wd};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        up_rd = up_rsp.prdata;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        // Let the write settle before the caller looks at outputs
        #1;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    // Single-cycle pulse on a wake input
    task pulse(input logic own);
        @(posedge pclk);
        own_wake_event <= own;
        fwd_wake_event <= ~own;
        @(posedge pclk);
        own_wake_event <= 1'b0;
        fwd_wake_event <= 1'b0;
        #1;
    endtask

    // =====================================================
    // Test sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        hot_reset = 1'b0;
        own_wake_event = 1'b0;
        fwd_wake_event = 1'b0;
        apb_req = '0;
        num_errors = 0;
        checked = 0;
        cycles = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(12'h0c4, 32'h0000_0008);
        chk({31'h0, context_kept_flag}, 32'h1);
        wr(12'h0c4, 32'hffff_ffff);
        rdchk(12'h0c4, 32'h0000_010b);
        chk({30'h0, power_state_field}, 32'h3);
        for (int c = 1; c < 3; c++) begin
            wr(12'h0c4, 32'h0000_0100 | c);
            rdchk(12'h0c4, 32'h0000_0103);
        end
        chk({31'h0, context_kept_flag}, 32'h0);
        rdchk(12'h100, 32'h0000_0002);
        wr(12'h100, 32'h0000_0003);
        wr(12'h104, 32'h0000_0000);
        pulse(1'b1);
        chk({31'h0, wake_msg_req}, 32'h1);
        chk({31'h0, up_msg}, 32'h0);
        rdchk(12'h0c4, 32'h0000_8103);
        chk(up_rd, 32'h0000_0103);
        chk({31'h0, irq}, 32'h0);
        rdchk(12'h100, 32'h0000_0001);
        wr(12'h104, 32'h0000_0001);
        rdchk(12'h104, 32'h0000_0001);
        chk({31'h0, irq}, 32'h1);
        wr(12'h100, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0);
        @(posedge pclk);
        hot_reset <= 1'b1;
        @(posedge pclk);
        hot_reset <= 1'b0;
        rdchk(12'h0c4, 32'h0000_8108);
        wr(12'h0c4, 32'h0000_8000);
        rdchk(12'h0c4, 32'h0000_0000);
        pulse(1'b1);
        chk({31'h0, wake_msg_req}, 32'h0);
        rdchk(12'h0c4, 32'h0000_8000);
        wr(12'h0c4, 32'h0000_8000);
        pulse(1'b0);
        rdchk(12'h0c4, 32'h0000_0000);
        rdchk(12'h200, 32'h0000_0000);
        chk({31'h0, err}, 32'h1);
        rdchk(12'h108, 32'h0000_0000);
        chk({31'h0, err}, 32'h0);
        wr(12'h0c4, 32'h0000_0100);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(12'h0c4, 32'h0000_0008);
        wr(12'h0c4, 32'h0000_0108);
        rdchk(12'h0c4, 32'h0000_0108);
        give_verdict;
    end
endmodule
